/* logic/rct_pkg.sv */
// rct_pkg: constants, types and helpers of the repeat cycle timer with batch counter
// assumes a 10 MHz system clock; every figure the top and the store share lives here
package rct_pkg;

    // time base: 10 MHz clock, finest step 0.01 s
    localparam int CLK_HZ = 10000000;
    localparam int BASE_TICK_US = 10000;
    localparam int BASE_TICK_CYC = CLK_HZ / 1000000 * BASE_TICK_US;
    // operator reset must finish within this time (longest, rounded down)
    localparam int RESET_TIME_MS = 15;
    localparam int RESET_CYC = CLK_HZ / 1000 * RESET_TIME_MS;
    // resume after power-up within this time (longest, rounded down)
    localparam int POWERON_MS = 200;
    localparam int POWERON_CYC = CLK_HZ / 1000 * POWERON_MS;

    // register port widths and offsets
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] REG_FIRST_SP = 4'h0;
    localparam logic [3:0] REG_SECOND_SP = 4'h1;
    localparam logic [3:0] REG_BATCH = 4'h2;
    localparam logic [3:0] REG_CTRL = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ELAPSED = 4'h5;
    localparam logic [3:0] REG_COUNT = 4'h6;
    localparam logic [3:0] REG_DISPLAY = 4'h7;

    // control register fields and reset value
    localparam int CTRL_CONT_BIT = 0;
    localparam int CTRL_UP_BIT = 1;
    localparam int CTRL_LOCK_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // persistent store layout
    localparam int STORE_AW = 3;
    localparam int STORE_WORDS = 8;
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_SECOND = 3'h1;
    localparam logic [2:0] SLOT_BATCH = 3'h2;
    localparam logic [2:0] SLOT_ELAPSED = 3'h3;
    localparam logic [2:0] SLOT_COUNT = 3'h4;
    localparam logic [2:0] LOAD_DONE_IDX = 3'h5;

    // setpoint limits and reset values
    localparam logic [15:0] BATCH_MIN = 16'h0001;
    localparam logic [15:0] BATCH_MAX = 16'h270F;
    localparam logic [15:0] SP_RESET = 16'h0001;
    localparam logic [2:0] RANGE_MMSS = 3'h2;
    localparam logic [2:0] RANGE_HHMM = 3'h5;

    typedef enum logic [1:0] {
        MODE_ONDELAY = 2'b00,
        MODE_INTERVAL = 2'b01,
        MODE_SEQUENCE = 2'b10
    } rct_mode_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_ON = 2'b01,
        ST_OFF = 2'b10,
        ST_DONE = 2'b11
    } rct_state_t;

    typedef enum logic [1:0] {
        PR_NONE = 2'b00,
        PR_ON = 2'b01,
        PR_OFF = 2'b10,
        PR_COUNT = 2'b11
    } rct_prompt_t;

    // base ticks (0.01 s) per display step for each of the eight ranges
    function automatic logic [15:0] range_div(input logic [2:0] r);
        case (r)
            3'h0: range_div = 16'h0001;
            3'h1: range_div = 16'h000A;
            3'h2: range_div = 16'h0064;
            3'h3: range_div = 16'h003C;
            3'h4: range_div = 16'h0258;
            3'h5: range_div = 16'h1770;
            3'h6: range_div = 16'h0E10;
            default: range_div = 16'h8CA0;
        endcase
    endfunction

    // four bcd digits to step count; clock formats weigh the upper pair by 60
    function automatic logic [15:0] bcd_to_units(input logic [15:0] v, input logic clk_fmt);
        logic [15:0] hi;
        logic [15:0] lo;
        hi = 16'(v[15:12]) * 16'h000A + 16'(v[11:8]);
        lo = 16'(v[7:4]) * 16'h000A + 16'(v[3:0]);
        if (clk_fmt) begin
            bcd_to_units = hi * 16'h003C + lo;
        end else begin
            bcd_to_units = hi * 16'h0064 + lo;
        end
    endfunction

    // batch setpoint must lie in 1..9999
    function automatic logic batch_ok(input logic [15:0] v);
        batch_ok = (v >= BATCH_MIN) && (v <= BATCH_MAX);
    endfunction

endpackage

/* logic/rct_persistent_settings_store.sv */
// rct_persistent_settings_store: small retained memory for setpoints and run data
// assumes one writer and one reader in the clk_sys domain; contents survive rst
`timescale 1ns/100ps
module rct_persistent_settings_store (
    // clock
    input wire logic clk_sys,
    // write port
    input wire logic we,
    input wire logic [rct_pkg::STORE_AW-1:0] waddr,
    input wire logic [rct_pkg::DATA_W-1:0] wdata,
    // read port, data one cycle after the address
    input wire logic [rct_pkg::STORE_AW-1:0] raddr,
    output logic [rct_pkg::DATA_W-1:0] rdata_q
);

    // the array has no reset on purpose: rst models a power cycle, the data must outlive it
    // factory-blank at first power-up; an initialiser, since the write process owns the array
    logic [rct_pkg::DATA_W-1:0] mem_q [rct_pkg::STORE_WORDS] = '{default: 16'h0000};

    // write side
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    // registered read side
    always_ff @(posedge clk_sys) begin
        rdata_q <= mem_q[raddr];
    end

endmodule

/* logic/rct_top.sv */
// rct_top: repeat cycle timer with batch counter, two relay outputs and lamps
// assumes all inputs synchronous to clk_sys; rear switches static while running
`timescale 1ns/100ps
module rct_top #(
    parameter int TICK_CYC = rct_pkg::BASE_TICK_CYC // 0.01 s in clocks
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [rct_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rct_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rct_pkg::DATA_W-1:0] reg_rdata_q,
    // keypad
    input wire logic key_set,
    input wire logic key_ent,
    input wire logic [rct_pkg::DATA_W-1:0] key_value,
    input wire logic key_reset,
    // rear switches
    input wire logic [1:0] sw_mode,
    input wire logic [2:0] sw_range,
    // remote inputs
    input wire logic remote_reset,
    input wire logic inhibit,
    // relays, lamps, display
    output logic out1_q,
    output logic out2_q,
    output logic lamp1_q,
    output logic lamp2_q,
    output logic timing_lamp_q,
    output logic [1:0] prompt_q,
    output logic [rct_pkg::DATA_W-1:0] display_q
);

    rct_pkg::rct_state_t state_q; // timer phase
    rct_pkg::rct_prompt_t prmt_q; // keypad entry step
    rct_pkg::rct_mode_t mode; // rear switch mode
    logic [15:0] first_interval_setpoint_q; // on time, bcd
    logic [15:0] second_interval_setpoint_q; // off time, bcd
    logic [15:0] batch_q; // batch setpoint, binary
    logic [2:0] ctrl_q; // continuous, count up, lock
    logic [15:0] elapsed_q; // steps in current interval
    logic [15:0] count_q; // completed cycles
    logic [16:0] div_q; // base tick divider
    logic [15:0] pre_q; // range prescaler
    logic [2:0] load_idx_q; // power-up read pointer
    logic flush_sel_q; // which run word to save next
    logic [15:0] store_rdata;
    logic base_tick, unit_tick, run_en, at_end, cycle_end, batch_hit, op_reset;
    logic [15:0] target, count_next;
    logic sp_wr_en, key_ok, bus_sp;
    logic [2:0] sp_slot, st_waddr;
    logic [15:0] sp_data, st_wdata;
    logic out1_d, out2_d;
    logic cont, lock, up;

    assign mode = rct_pkg::rct_mode_t'(sw_mode);
    assign cont = ctrl_q[rct_pkg::CTRL_CONT_BIT];
    assign up = ctrl_q[rct_pkg::CTRL_UP_BIT];
    assign lock = ctrl_q[rct_pkg::CTRL_LOCK_BIT];

    // operator reset is ignored while restoring, so stored data cannot overwrite it
    assign op_reset = (key_reset || remote_reset) && (state_q != rct_pkg::ST_LOAD);
    // inhibit freezes the whole time base, so partial steps are not lost
    assign run_en = (state_q == rct_pkg::ST_ON || state_q == rct_pkg::ST_OFF) && !inhibit;
    assign base_tick = run_en && (div_q == 17'(TICK_CYC - 1));
    assign unit_tick = base_tick && (pre_q == rct_pkg::range_div(sw_range) - 16'h0001);

    // interval length in steps, never below one step
    always_comb begin
        target = rct_pkg::bcd_to_units(
            (state_q == rct_pkg::ST_ON) ? first_interval_setpoint_q : second_interval_setpoint_q,
            (sw_range == rct_pkg::RANGE_MMSS) || (sw_range == rct_pkg::RANGE_HHMM));
        if (target == 16'h0000) begin
            target = 16'h0001;
        end
    end

    assign at_end = unit_tick && (elapsed_q + 16'h0001 >= target);
    assign cycle_end = at_end && (state_q == rct_pkg::ST_OFF);
    assign count_next = (count_q == rct_pkg::BATCH_MAX) ? count_q : count_q + 16'h0001;
    assign batch_hit = !cont && (count_next >= batch_q);

    // base divider: one pulse every 0.01 s of running time
    always_ff @(posedge clk_sys) begin
        if (rst || op_reset) begin
            div_q <= 17'h00000;
        end else if (run_en) begin
            div_q <= base_tick ? 17'h00000 : div_q + 17'h00001;
        end
    end

    // range prescaler: base ticks per displayed step
    always_ff @(posedge clk_sys) begin
        if (rst || op_reset) begin
            pre_q <= 16'h0000;
        end else if (unit_tick) begin
            pre_q <= 16'h0000;
        end else if (base_tick) begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    // power-up restore pointer: reads slots 0..4, data lands one cycle later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_idx_q <= 3'h0;
        end else if (state_q == rct_pkg::ST_LOAD) begin
            load_idx_q <= load_idx_q + 3'h1;
        end
    end

    // timer phase machine
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= rct_pkg::ST_LOAD;
        end else if (op_reset) begin
            state_q <= rct_pkg::ST_ON;
        end else begin
            case (state_q)
                rct_pkg::ST_LOAD: begin
                    if (load_idx_q == rct_pkg::LOAD_DONE_IDX) begin
                        // a batch already finished before power loss stays finished
                        state_q <= (!cont && store_rdata >= batch_q) ? rct_pkg::ST_DONE
                                                                     : rct_pkg::ST_ON;
                    end
                end
                rct_pkg::ST_ON: begin
                    if (at_end) begin
                        state_q <= rct_pkg::ST_OFF;
                    end
                end
                rct_pkg::ST_OFF: begin
                    if (cycle_end) begin
                        state_q <= batch_hit ? rct_pkg::ST_DONE : rct_pkg::ST_ON;
                    end
                end
                rct_pkg::ST_DONE: begin
                    state_q <= rct_pkg::ST_DONE;
                end
                default: begin
                    state_q <= rct_pkg::ST_LOAD;
                end
            endcase
        end
    end

    // elapsed steps within the running interval
    always_ff @(posedge clk_sys) begin
        if (rst || op_reset) begin
            elapsed_q <= 16'h0000;
        end else if (state_q == rct_pkg::ST_LOAD &&
                     load_idx_q == rct_pkg::SLOT_ELAPSED + 3'h1) begin
            elapsed_q <= store_rdata;
        end else if (at_end) begin
            elapsed_q <= 16'h0000;
        end else if (unit_tick) begin
            elapsed_q <= elapsed_q + 16'h0001;
        end
    end

    // completed cycle count; held once the batch is done
    always_ff @(posedge clk_sys) begin
        if (rst || op_reset) begin
            count_q <= 16'h0000;
        end else if (state_q == rct_pkg::ST_LOAD && load_idx_q == rct_pkg::LOAD_DONE_IDX) begin
            count_q <= store_rdata;
        end else if (cycle_end) begin
            count_q <= count_next;
        end
    end

    // setpoint writes: the bus wins over the keypad; keypad only when unlocked
    assign bus_sp = reg_wr && (reg_addr <= rct_pkg::REG_BATCH);
    assign key_ok = key_ent && !lock && (prmt_q != rct_pkg::PR_NONE);
    always_comb begin
        sp_slot = bus_sp ? reg_addr[2:0] : 3'(prmt_q - 2'b01);
        sp_data = bus_sp ? reg_wdata : key_value;
        sp_wr_en = bus_sp || key_ok;
        if (sp_slot == rct_pkg::SLOT_BATCH && !rct_pkg::batch_ok(sp_data)) begin
            sp_wr_en = 1'b0;
        end
    end

    // setpoint registers, restored at power-up and written by bus or keypad
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_interval_setpoint_q <= rct_pkg::SP_RESET;
            second_interval_setpoint_q <= rct_pkg::SP_RESET;
            batch_q <= rct_pkg::BATCH_MIN;
        end else if (state_q == rct_pkg::ST_LOAD) begin
            case (load_idx_q)
                3'h1: first_interval_setpoint_q <= store_rdata;
                3'h2: second_interval_setpoint_q <= store_rdata;
                3'h3: begin
                    // a blank or corrupt batch word keeps the default
                    if (rct_pkg::batch_ok(store_rdata)) begin
                        batch_q <= store_rdata;
                    end
                end
                default: begin
                end
            endcase
        end else if (sp_wr_en) begin
            case (sp_slot)
                rct_pkg::SLOT_FIRST: first_interval_setpoint_q <= sp_data;
                rct_pkg::SLOT_SECOND: second_interval_setpoint_q <= sp_data;
                default: batch_q <= sp_data;
            endcase
        end
    end

    // control register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= rct_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == rct_pkg::REG_CTRL) begin
            ctrl_q <= reg_wdata[2:0];
        end
    end

    // keypad prompt sequence: set key steps on time, off time, batch, back to run
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prmt_q <= rct_pkg::PR_NONE;
        end else if (key_set) begin
            case (prmt_q)
                rct_pkg::PR_NONE: prmt_q <= rct_pkg::PR_ON;
                rct_pkg::PR_ON: prmt_q <= rct_pkg::PR_OFF;
                rct_pkg::PR_OFF: prmt_q <= rct_pkg::PR_COUNT;
                default: prmt_q <= rct_pkg::PR_NONE;
            endcase
        end
    end

    // store write: setpoints first, otherwise alternately save elapsed and count
    always_comb begin
        if (sp_wr_en && state_q != rct_pkg::ST_LOAD) begin
            st_waddr = sp_slot;
            st_wdata = sp_data;
        end else if (flush_sel_q) begin
            st_waddr = rct_pkg::SLOT_COUNT;
            st_wdata = count_q;
        end else begin
            st_waddr = rct_pkg::SLOT_ELAPSED;
            st_wdata = elapsed_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flush_sel_q <= 1'b0;
        end else begin
            flush_sel_q <= !flush_sel_q;
        end
    end

    rct_persistent_settings_store u_store (
        .clk_sys(clk_sys),
        .we(state_q != rct_pkg::ST_LOAD),
        .waddr(st_waddr),
        .wdata(st_wdata),
        .raddr(load_idx_q),
        .rdata_q(store_rdata)
    );

    // relay decode per counter mode
    always_comb begin
        out1_d = 1'b0;
        out2_d = 1'b0;
        case (mode)
            rct_pkg::MODE_ONDELAY: begin
                out2_d = (state_q == rct_pkg::ST_ON);
                out1_d = (state_q == rct_pkg::ST_DONE);
            end
            rct_pkg::MODE_INTERVAL: begin
                out2_d = (state_q == rct_pkg::ST_ON);
                out1_d = (state_q == rct_pkg::ST_ON) || (state_q == rct_pkg::ST_OFF);
            end
            default: begin
                out1_d = (state_q == rct_pkg::ST_ON);
                out2_d = (state_q == rct_pkg::ST_OFF);
            end
        endcase
    end

    // relays and lamps, one cycle behind the phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out1_q <= 1'b0;
            out2_q <= 1'b0;
            lamp1_q <= 1'b0;
            lamp2_q <= 1'b0;
            timing_lamp_q <= 1'b0;
        end else begin
            out1_q <= out1_d;
            out2_q <= out2_d;
            lamp1_q <= out1_d;
            lamp2_q <= out2_d;
            timing_lamp_q <= run_en;
        end
    end

    // display: prompted setpoint, else cycle progress in chosen direction
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            display_q <= 16'h0000;
            prompt_q <= 2'b00;
        end else begin
            prompt_q <= prmt_q;
            case (prmt_q)
                rct_pkg::PR_ON: display_q <= first_interval_setpoint_q;
                rct_pkg::PR_OFF: display_q <= second_interval_setpoint_q;
                rct_pkg::PR_COUNT: display_q <= batch_q;
                default: begin
                    if (up || count_q >= batch_q) begin
                        display_q <= up ? count_q : 16'h0000;
                    end else begin
                        display_q <= batch_q - count_q;
                    end
                end
            endcase
        end
    end

    // register read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst || !reg_rd) begin
            reg_rdata_q <= 16'h0000;
        end else begin
            case (reg_addr)
                rct_pkg::REG_FIRST_SP: reg_rdata_q <= first_interval_setpoint_q;
                rct_pkg::REG_SECOND_SP: reg_rdata_q <= second_interval_setpoint_q;
                rct_pkg::REG_BATCH: reg_rdata_q <= batch_q;
                rct_pkg::REG_CTRL: reg_rdata_q <= {13'h0000, ctrl_q};
                rct_pkg::REG_STATUS: reg_rdata_q <= {11'h000, inhibit,
                    state_q == rct_pkg::ST_DONE, run_en, out2_q, out1_q};
                rct_pkg::REG_ELAPSED: reg_rdata_q <= elapsed_q;
                rct_pkg::REG_COUNT: reg_rdata_q <= count_q;
                rct_pkg::REG_DISPLAY: reg_rdata_q <= display_q;
                default: reg_rdata_q <= 16'h0000;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_batch_halt: assert property (cycle_end && batch_hit && !op_reset |=>
        state_q == rct_pkg::ST_DONE ##1 state_q == rct_pkg::ST_DONE)
        else $error("batch end did not halt cycling");
    chk_off_setpoint: assert property (reg_wr && reg_addr == rct_pkg::REG_SECOND_SP |=>
        second_interval_setpoint_q == $past(reg_wdata) && $stable(first_interval_setpoint_q))
        else $error("off setpoint write wrong");
    chk_batch_range: assert property (batch_q >= 16'h0001 && batch_q <= 16'h270F)
        else $error("batch setpoint out of range");
    chk_ondelay_out: assert property (mode == rct_pkg::MODE_ONDELAY &&
        state_q == rct_pkg::ST_DONE && !op_reset |=> out1_q && !out2_q)
        else $error("on-delay outputs wrong at batch end");
    chk_interval_out: assert property (mode == rct_pkg::MODE_INTERVAL &&
        state_q == rct_pkg::ST_OFF && !at_end |=> out1_q && !out2_q)
        else $error("interval outputs wrong in off phase");
    chk_seq_out: assert property (mode == rct_pkg::MODE_SEQUENCE &&
        state_q == rct_pkg::ST_ON && !at_end && !op_reset |=> out1_q && !out2_q)
        else $error("sequence outputs wrong in first interval");
    chk_seq_done: assert property (mode == rct_pkg::MODE_SEQUENCE &&
        state_q == rct_pkg::ST_DONE |=> !out1_q && !out2_q)
        else $error("sequence mode drove output after batch");
    chk_reset_clear: assert property (op_reset |=>
        count_q == 16'h0000 && elapsed_q == 16'h0000 && state_q == rct_pkg::ST_ON)
        else $error("operator reset incomplete");
    chk_power_on: assert property (state_q == rct_pkg::ST_LOAD |->
        ##[1:6] state_q != rct_pkg::ST_LOAD)
        else $error("power-up restore too slow");
    chk_lamp_follow: assert property (lamp1_q == out1_q && lamp2_q == out2_q)
        else $error("lamp differs from relay");
    chk_inhibit_hold: assert property (inhibit && !op_reset |=>
        $stable(elapsed_q) && $stable(state_q) ##1 $stable(out1_q) && $stable(out2_q))
        else $error("inhibit did not pause timing");
    chk_lock_refuse: assert property (key_ent && lock && !reg_wr &&
        state_q != rct_pkg::ST_LOAD |=> $stable(first_interval_setpoint_q) &&
        $stable(second_interval_setpoint_q) && $stable(batch_q))
        else $error("locked keypad changed setpoint");
    chk_done_hold: assert property (state_q == rct_pkg::ST_DONE && !op_reset |=>
        state_q == rct_pkg::ST_DONE && $stable(count_q))
        else $error("batch result not held");

    cov_ondelay_done: cover property (mode == rct_pkg::MODE_ONDELAY && out1_q);
    cov_seq_cycle: cover property (state_q == rct_pkg::ST_OFF ##1 state_q == rct_pkg::ST_ON);
    cov_inhibit_run: cover property (inhibit && state_q == rct_pkg::ST_ON);
    cov_prompt_walk: cover property (prmt_q == rct_pkg::PR_COUNT && key_ent && !lock);

endmodule

/* tb/rct_panel_model.sv */
// rct_panel_model: operator keypad, rear switches and remote inputs
// assumes callers wait on clk_sys; every change lands just after a rising edge
`timescale 1ns/100ps
module rct_panel_model (
    // clock
    input wire logic clk_sys,
    // keypad and panel reset key
    output logic key_set,
    output logic key_ent,
    output logic [rct_pkg::DATA_W-1:0] key_value,
    output logic key_reset,
    // rear switches and remote inputs
    output logic [1:0] sw_mode,
    output logic [2:0] sw_range,
    output logic remote_reset,
    output logic inhibit
);
    // idle panel; range 0 keeps one step at one base tick
    initial begin
        {key_set, key_ent, key_reset, remote_reset, inhibit} = 5'h00;
        key_value = 16'h0000;
        sw_range = 3'h0;
        sw_mode = 2'h0;
    end
    // rear switch moved only between runs, never while timing
    task automatic switch_mode(input logic [1:0] m);
        @(posedge clk_sys);
        sw_mode <= m;
    endtask
    // rear range switch, moved only between runs
    task automatic set_range(input logic [2:0] r);
        @(posedge clk_sys);
        sw_range <= r;
    endtask
    // one-cycle key press: set when ent is low, enter when high
    task automatic press(input logic ent, input logic [15:0] v);
        @(posedge clk_sys);
        key_set <= !ent;
        key_ent <= ent;
        key_value <= v;
        @(posedge clk_sys);
        key_set <= 1'b0;
        key_ent <= 1'b0;
    endtask
    // one-cycle operator reset from the panel key or the remote line
    task automatic restart(input logic remote);
        @(posedge clk_sys);
        key_reset <= !remote;
        remote_reset <= remote;
        @(posedge clk_sys);
        key_reset <= 1'b0;
        remote_reset <= 1'b0;
    endtask
    // inhibit level, held for as long as the caller wants timing frozen
    task automatic hold(input logic h);
        @(posedge clk_sys);
        inhibit <= h;
    endtask
endmodule

/* tb/repeat_cycle_timer_batch_counter_test.sv */
// repeat_cycle_timer_batch_counter_test: self-checking bench for rct_top
// assumes TICK_CYC of 2 and range 0, so one timing step is two clocks
`timescale 1ns/100ps
module repeat_cycle_timer_batch_counter_test;
    logic clk_sys, rst, reg_wr, reg_rd, key_set, key_ent, key_reset, remote_reset, inhibit;
    logic [rct_pkg::ADDR_W-1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q, display_q, key_value, v;
    logic [1:0] sw_mode, prompt_q;
    logic [2:0] sw_range;
    logic out1_q, out2_q, lamp1_q, lamp2_q, timing_lamp_q;
    int mismatches = 0;
    int check_count = 0;
    rct_panel_model u_panel (.clk_sys(clk_sys), .key_set(key_set), .key_ent(key_ent),
        .key_value(key_value), .key_reset(key_reset), .sw_mode(sw_mode), .sw_range(sw_range),
        .remote_reset(remote_reset), .inhibit(inhibit));
    rct_top #(.TICK_CYC(2)) u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .key_set(key_set), .key_ent(key_ent), .key_value(key_value), .key_reset(key_reset),
        .sw_mode(sw_mode), .sw_range(sw_range), .remote_reset(remote_reset), .inhibit(inhibit),
        .out1_q(out1_q), .out2_q(out2_q), .lamp1_q(lamp1_q), .lamp2_q(lamp2_q),
        .timing_lamp_q(timing_lamp_q), .prompt_q(prompt_q), .display_q(display_q));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata_q;
        chk(v, exp);
    endtask
    // on-phase outputs early, then held final state, count and lamps
    task automatic run_mode(input logic [1:0] m, input logic r, input logic [1:0] on,
        input logic [15:0] st);
        u_panel.switch_mode(m);
        u_panel.restart(r);
        repeat (3) @(posedge clk_sys);
        #1 chk(16'({timing_lamp_q, out2_q, out1_q}), 16'({1'b1, on}));
        repeat (200) @(posedge clk_sys);
        rchk(rct_pkg::REG_STATUS, st);
        rchk(rct_pkg::REG_COUNT, 16'h0002);
        chk(16'({timing_lamp_q, lamp2_q, lamp1_q}), 16'(st[2:0]));
    endtask
    // out-of-range batch refused; continuous never finishes
    task automatic batch_limits();
        wr(rct_pkg::REG_BATCH, 16'h0000);
        wr(rct_pkg::REG_BATCH, 16'h2710);
        rchk(rct_pkg::REG_BATCH, 16'h0002);
        wr(rct_pkg::REG_CTRL, 16'h0001);
        u_panel.restart(1'b1);
        repeat (200) @(posedge clk_sys);
        rchk(rct_pkg::REG_STATUS, 16'h0006);
        wr(rct_pkg::REG_CTRL, 16'h0000);
    endtask
    // frozen elapsed time and outputs while inhibited, one step into the on time
    task automatic hold_check();
        u_panel.restart(1'b1);
        @(posedge clk_sys);
        u_panel.hold(1'b1);
        repeat (3) @(posedge clk_sys);
        rchk(rct_pkg::REG_ELAPSED, 16'h0001);
        repeat (30) @(posedge clk_sys);
        rchk(rct_pkg::REG_ELAPSED, 16'h0001);
        chk(16'(out1_q), 16'h0001);
        u_panel.hold(1'b0);
    endtask
    // prompts in order; locked entry refused, unlocked entry taken
    task automatic keypad();
        wr(rct_pkg::REG_CTRL, 16'h0004);
        u_panel.press(1'b0, 16'h0000);
        @(posedge clk_sys);
        #1 chk(16'(prompt_q), 16'h0001);
        u_panel.press(1'b1, 16'h0042);
        rchk(rct_pkg::REG_FIRST_SP, 16'h0005);
        wr(rct_pkg::REG_CTRL, 16'h0000);
        u_panel.press(1'b1, 16'h0007);
        rchk(rct_pkg::REG_FIRST_SP, 16'h0007);
        rchk(rct_pkg::REG_SECOND_SP, 16'h0003);
        u_panel.press(1'b0, 16'h0000);
        u_panel.press(1'b0, 16'h0000);
        @(posedge clk_sys);
        #1 chk(16'(prompt_q), 16'h0003);
        chk(display_q, 16'h0002);
    endtask
    // tenth-second range: ten base ticks make one step
    task automatic range_check();
        u_panel.set_range(3'h1);
        u_panel.restart(1'b0);
        repeat (29) @(posedge clk_sys);
        rchk(rct_pkg::REG_ELAPSED, 16'h0001);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // whole run is near 1000 clocks; give it twenty times that
    initial begin
        #2000000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 4'h0, 16'h0000};
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1 chk(16'({out2_q, out1_q}), 16'h0000);
        repeat (8) @(posedge clk_sys);
        wr(rct_pkg::REG_FIRST_SP, 16'h0005);
        wr(rct_pkg::REG_SECOND_SP, 16'h0003);
        wr(rct_pkg::REG_BATCH, 16'h0002);
        batch_limits();
        run_mode(2'h0, 1'b0, 2'b10, 16'h0009);
        rchk(rct_pkg::REG_DISPLAY, 16'h0000);
        wr(rct_pkg::REG_CTRL, 16'h0002);
        rchk(rct_pkg::REG_DISPLAY, 16'h0002);
        wr(rct_pkg::REG_CTRL, 16'h0000);
        run_mode(2'h1, 1'b1, 2'b11, 16'h0008);
        run_mode(2'h2, 1'b1, 2'b01, 16'h0008);
        hold_check();
        keypad();
        range_check();
        tally_and_finish();
    end
endmodule
